// ### hdl/pco_pkg.sv
package pco_pkg;

  // Bus and word geometry
  localparam int PCO_DATA_W = 32;
  localparam int PCO_ADDR_W = 12;
  localparam logic [PCO_DATA_W-1:0] PCO_RST_WORD = 32'h0000_0000;

  // Register byte offsets
  localparam logic [PCO_ADDR_W-1:0] PCO_OFS_INSTR = 12'h000;
  localparam logic [PCO_ADDR_W-1:0] PCO_OFS_SRC = 12'h004;
  localparam logic [PCO_ADDR_W-1:0] PCO_OFS_DST = 12'h008;
  localparam logic [PCO_ADDR_W-1:0] PCO_OFS_COND = 12'h00C;
  localparam logic [PCO_ADDR_W-1:0] PCO_OFS_FXE = 12'h010;
  localparam logic [PCO_ADDR_W-1:0] PCO_OFS_STATUS = 12'h014;

  // Status word layout
  localparam int PCO_ST_BUSY = 0;
  localparam int PCO_ST_SYNC = 1;
  localparam int PCO_ST_ISYNC = 2;
  localparam int PCO_ST_SPR_MISS = 3;
  localparam int PCO_ST_BAD_OP = 4;
  localparam int PCO_ST_REG_LO = 8;
  localparam int PCO_REG_IDX_W = 5;

  // AHB transfer type bit that marks NONSEQ or SEQ
  localparam int PCO_HTRANS_ACTIVE = 1;

  // Condition register geometry, bit 0 of the architecture is the word msb
  localparam int PCO_CR_FIELD_W = 4;
  localparam int PCO_CR_FIELDS = 8;
  localparam int PCO_CRF_W = 3;
  localparam int PCO_FXE_HI = 31;
  localparam int PCO_FXE_LO = 28;

  // Instruction field positions
  localparam int PCO_PRIM_HI = 31;
  localparam int PCO_PRIM_LO = 26;
  localparam int PCO_XO_HI = 10;
  localparam int PCO_XO_LO = 1;
  localparam int PCO_REG_HI = 25;
  localparam int PCO_REG_LO = 21;
  localparam int PCO_CRF_HI = 25;
  localparam int PCO_CRF_LO = 23;
  localparam int PCO_CRM_HI = 19;
  localparam int PCO_CRM_LO = 12;
  localparam int PCO_SPRF_HI = 20;
  localparam int PCO_SPRF_MID = 16;
  localparam int PCO_SPRF_LO = 11;
  localparam int PCO_SPECIAL_REG_NUMBER_W = 10;

  // Opcode values
  localparam logic [5:0] PCO_PRIM_X = 6'h1F;
  localparam logic [5:0] PCO_PRIM_XL = 6'h13;
  localparam logic [9:0] PCO_XO_MCRXR = 10'h200;
  localparam logic [9:0] PCO_XO_MFCR = 10'h013;
  localparam logic [9:0] PCO_XO_MTCRF = 10'h090;
  localparam logic [9:0] PCO_XO_MFSPR = 10'h153;
  localparam logic [9:0] PCO_XO_MTSPR = 10'h1D3;
  localparam logic [9:0] PCO_XO_EIEIO = 10'h356;
  localparam logic [9:0] PCO_XO_SYNC = 10'h256;
  localparam logic [9:0] PCO_XO_ISYNC = 10'h096;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_EXEC = 3'b001,
    ST_SYNC = 3'b010,
    ST_ISYNC = 3'b011,
    ST_FLUSH = 3'b100
  } pco_state_type;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_MCRXR = 3'b001,
    OP_MFCR = 3'b010,
    OP_MTCRF = 3'b011,
    OP_MFSPR = 3'b100,
    OP_MTSPR = 3'b101,
    OP_SYNC = 3'b110,
    OP_ISYNC = 3'b111
  } pco_op_type;

  typedef struct packed {
    logic hsel;
    logic [PCO_DATA_W-1:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [PCO_DATA_W-1:0] hwdata;
    logic hready;
  } pco_ahb_req_type;

  typedef struct packed {
    logic [PCO_DATA_W-1:0] hrdata;
    logic hreadyout;
    logic hresp;
  } pco_ahb_rsp_type;

  typedef struct packed {
    logic older_busy;
    logic mem_busy;
  } pco_core_in_type;

  typedef struct packed {
    logic issue_stall;
    logic mem_hold;
    logic fetch_flush;
  } pco_core_out_type;

  function automatic pco_op_type pco_decode(input logic [PCO_DATA_W-1:0] ins);
    logic [5:0] prim;
    logic [9:0] xo;
    pco_op_type op;
    prim = ins[PCO_PRIM_HI:PCO_PRIM_LO];
    xo = ins[PCO_XO_HI:PCO_XO_LO];
    op = OP_NONE;
    if (prim == PCO_PRIM_X) begin
      if (xo == PCO_XO_MCRXR) op = OP_MCRXR;
      else if (xo == PCO_XO_MFCR) op = OP_MFCR;
      else if (xo == PCO_XO_MTCRF) op = OP_MTCRF;
      else if (xo == PCO_XO_MFSPR) op = OP_MFSPR;
      else if (xo == PCO_XO_MTSPR) op = OP_MTSPR;
      else if (xo == PCO_XO_EIEIO || xo == PCO_XO_SYNC) op = OP_SYNC;
    end else if (prim == PCO_PRIM_XL && xo == PCO_XO_ISYNC) begin
      op = OP_ISYNC;
    end
    return op;
  endfunction : pco_decode

endpackage : pco_pkg

// ### hdl/pco_top.sv
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
// Function
// RULE1 - Exception-to-condition move copies exception bits 0..3 into the chosen field.
// RULE2 - That move then clears exception bits 0..3.
// RULE3 - Condition read puts the whole 32-bit condition word in the destination.
// RULE4 - Masked condition write loads condition fields from source under mask.
// RULE5 - The field mask is an 8-bit instruction field, one bit per field.
// RULE6 - Mask msb selects field 0, lsb field 7; fields are 4 bits.
// RULE7 - Field loads only when its mask bit is 1, else keeps value.
// RULE8 - Special read copies the selected special register into the destination.
// RULE9 - Special write loads the selected special register from the source.
// RULE10 - Special register number is decoded from the split opcode field.
// RULE11 - Number rebuilt by swapping the two 5-bit halves of the field.
// RULE12 - Ordering barrier lets older loads and stores finish before younger ones.
// RULE13 - Instruction barrier completes only after all older instructions complete.
// RULE14 - No younger instruction starts while the instruction barrier is pending.
// RULE15 - Instruction barrier discards prefetched instructions and refetches them.
// RULE16 - Instruction barrier does not order memory accesses.
// RULE17 - Full barrier completes only after older instructions appear complete.
// RULE18 - No younger instruction executes until the full barrier completes.
// RULE19 - Full barrier completes older memory accesses against other devices first.
// RULE20 - Ordering barrier and full barrier behave identically.
// RULE21 - Ordering barrier is execution-synchronising and stalls younger instructions.
// RULE22 - No multiprocessor coherency; full barrier orders nothing across processors.
module pco_top #(
  parameter int SPR_DEPTH = 16,
  parameter int SPR_IDX_W = 4
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Register bus
  input wire pco_pkg::pco_ahb_req_type ahb_req,
  output pco_pkg::pco_ahb_rsp_type ahb_rsp,
  // Core pipeline and memory system
  input wire pco_pkg::pco_core_in_type core_in,
  output pco_pkg::pco_core_out_type core_out
);
  import pco_pkg::*;

  pco_state_type state_reg;
  logic [PCO_DATA_W-1:0] instr_reg;
  logic [PCO_DATA_W-1:0] src_reg;
  logic [PCO_DATA_W-1:0] dst_reg;
  logic [PCO_DATA_W-1:0] cond_reg;
  logic [PCO_DATA_W-1:0] cond_next;
  logic [PCO_DATA_W-1:0] fxe_reg;
  logic [PCO_DATA_W-1:0] spr_file [SPR_DEPTH];
  logic spr_miss_reg;
  logic bad_op_reg;
  logic dp_valid_reg;
  logic dp_write_reg;
  logic [PCO_ADDR_W-1:0] dp_addr_reg;
  logic [PCO_DATA_W-1:0] rdata;
  logic [PCO_DATA_W-1:0] status_word;
  logic busy;
  logic dp_stall;
  logic wr_ok;
  logic exec;
  pco_op_type op;
  logic [PCO_CRF_W-1:0] crf;
  logic [PCO_CR_FIELDS-1:0] field_write_mask;
  logic [PCO_SPECIAL_REG_NUMBER_W-1:0] spr_num;
  logic spr_hit;
  logic [SPR_IDX_W-1:0] spr_idx;
  logic [PCO_DATA_W-1:0] crm_wide;
  logic [PCO_DATA_W-1:0] crf_wide;
  logic [PCO_CR_FIELD_W-1:0] fxe_top;

  // Decode of the instruction being executed
  assign op = pco_decode(instr_reg);
  assign crf = instr_reg[PCO_CRF_HI:PCO_CRF_LO];
  assign field_write_mask = instr_reg[PCO_CRM_HI:PCO_CRM_LO]; // RULE5
  // Low half of the printed field is the high half of the number
  assign spr_num = {instr_reg[PCO_SPRF_MID-1:PCO_SPRF_LO],
                    instr_reg[PCO_SPRF_HI:PCO_SPRF_MID]}; // RULE10 RULE11
  assign spr_hit = (spr_num < PCO_SPECIAL_REG_NUMBER_W'(SPR_DEPTH));
  assign spr_idx = spr_num[SPR_IDX_W-1:0];
  assign fxe_top = fxe_reg[PCO_FXE_HI:PCO_FXE_LO];
  assign exec = (state_reg == ST_EXEC);
  assign busy = (state_reg != ST_IDLE);

  // Per-field mask expansion, field 0 at the word msb
  for (genvar i = 0; i < PCO_CR_FIELDS; i++) begin : g_field
    localparam int HI = PCO_DATA_W - 1 - PCO_CR_FIELD_W * i;
    assign crm_wide[HI -: PCO_CR_FIELD_W] =
      {PCO_CR_FIELD_W{field_write_mask[PCO_CR_FIELDS-1-i]}}; // RULE6
    assign crf_wide[HI -: PCO_CR_FIELD_W] =
      {PCO_CR_FIELD_W{crf == PCO_CRF_W'(i)}};
  end

  // Bus front end: only word accesses are expected, hsize is not checked
  // Everything but a status read waits while an instruction is in flight,
  // which is what keeps younger instructions from starting.
  assign dp_stall = dp_valid_reg && busy &&
                    !(!dp_write_reg && dp_addr_reg == PCO_OFS_STATUS); // RULE14 RULE18 RULE21
  assign wr_ok = dp_valid_reg && dp_write_reg && !dp_stall;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg <= '0;
    end else if (ahb_req.hready) begin
      dp_valid_reg <= ahb_req.hsel && ahb_req.htrans[PCO_HTRANS_ACTIVE];
      dp_write_reg <= ahb_req.hwrite;
      dp_addr_reg <= ahb_req.haddr[PCO_ADDR_W-1:0];
    end
  end

  always_comb begin
    status_word = PCO_RST_WORD;
    status_word[PCO_ST_BUSY] = busy;
    status_word[PCO_ST_SYNC] = (state_reg == ST_SYNC);
    status_word[PCO_ST_ISYNC] = (state_reg == ST_ISYNC) || (state_reg == ST_FLUSH);
    status_word[PCO_ST_SPR_MISS] = spr_miss_reg;
    status_word[PCO_ST_BAD_OP] = bad_op_reg;
    status_word[PCO_ST_REG_LO +: PCO_REG_IDX_W] = instr_reg[PCO_REG_HI:PCO_REG_LO];
  end

  // Read mux over flip-flops; unmapped reads give zero
  always_comb begin
    if (!dp_valid_reg || dp_write_reg) rdata = PCO_RST_WORD;
    else if (dp_addr_reg == PCO_OFS_INSTR) rdata = instr_reg;
    else if (dp_addr_reg == PCO_OFS_SRC) rdata = src_reg;
    else if (dp_addr_reg == PCO_OFS_DST) rdata = dst_reg;
    else if (dp_addr_reg == PCO_OFS_COND) rdata = cond_reg;
    else if (dp_addr_reg == PCO_OFS_FXE) rdata = fxe_reg;
    else if (dp_addr_reg == PCO_OFS_STATUS) rdata = status_word;
    else rdata = PCO_RST_WORD;
  end

  assign ahb_rsp.hrdata = rdata;
  assign ahb_rsp.hreadyout = !dp_stall;
  assign ahb_rsp.hresp = 1'b0;

  // Sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (wr_ok && dp_addr_reg == PCO_OFS_INSTR) state_reg <= ST_EXEC;
        end
        ST_EXEC: begin
          if (op == OP_SYNC) state_reg <= ST_SYNC; // RULE20
          else if (op == OP_ISYNC) state_reg <= ST_ISYNC;
          else state_reg <= ST_IDLE;
        end
        ST_SYNC: begin
          // Waits on local outstanding work only; no other processor is asked
          if (!core_in.older_busy && !core_in.mem_busy) begin
            state_reg <= ST_IDLE; // RULE12 RULE17 RULE19 RULE22
          end
        end
        ST_ISYNC: begin
          // Memory traffic is deliberately not waited for here
          if (!core_in.older_busy) state_reg <= ST_FLUSH; // RULE13 RULE16
        end
        ST_FLUSH: begin
          state_reg <= ST_IDLE; // RULE15
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  assign core_out.issue_stall = (state_reg == ST_SYNC) || (state_reg == ST_ISYNC) ||
                                (state_reg == ST_FLUSH); // RULE14 RULE18 RULE21
  assign core_out.mem_hold = (state_reg == ST_SYNC); // RULE12 RULE16
  assign core_out.fetch_flush = (state_reg == ST_FLUSH); // RULE15

  // Instruction and source operand latches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      instr_reg <= PCO_RST_WORD;
      src_reg <= PCO_RST_WORD;
    end else if (wr_ok) begin
      if (dp_addr_reg == PCO_OFS_INSTR) instr_reg <= ahb_req.hwdata;
      else if (dp_addr_reg == PCO_OFS_SRC) src_reg <= ahb_req.hwdata;
    end
  end

  // Condition register
  always_comb begin
    cond_next = cond_reg;
    if (exec && op == OP_MCRXR) begin
      cond_next = (cond_reg & ~crf_wide) |
                  ({PCO_CR_FIELDS{fxe_top}} & crf_wide); // RULE1
    end else if (exec && op == OP_MTCRF) begin
      cond_next = (cond_reg & ~crm_wide) | (src_reg & crm_wide); // RULE4 RULE7
    end else if (wr_ok && dp_addr_reg == PCO_OFS_COND) begin
      cond_next = ahb_req.hwdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cond_reg <= PCO_RST_WORD;
    else cond_reg <= cond_next;
  end

  // Fixed-point exception register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fxe_reg <= PCO_RST_WORD;
    end else if (exec && op == OP_MCRXR) begin
      fxe_reg[PCO_FXE_HI:PCO_FXE_LO] <= '0; // RULE2
    end else if (wr_ok && dp_addr_reg == PCO_OFS_FXE) begin
      fxe_reg <= ahb_req.hwdata;
    end
  end

  // Destination general register and last-op flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dst_reg <= PCO_RST_WORD;
      spr_miss_reg <= 1'b0;
      bad_op_reg <= 1'b0;
    end else if (exec) begin
      bad_op_reg <= (op == OP_NONE);
      spr_miss_reg <= (op == OP_MFSPR || op == OP_MTSPR) && !spr_hit;
      if (op == OP_MFCR) begin
        dst_reg <= cond_reg; // RULE3
      end else if (op == OP_MFSPR) begin
        // Unimplemented numbers read as zero rather than trapping
        dst_reg <= spr_hit ? spr_file[spr_idx] : PCO_RST_WORD; // RULE8
      end
    end
  end

  // Special-purpose register file
  for (genvar s = 0; s < SPR_DEPTH; s++) begin : g_spr
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        spr_file[s] <= PCO_RST_WORD;
      end else if (exec && op == OP_MTSPR && spr_hit && spr_idx == SPR_IDX_W'(s)) begin
        spr_file[s] <= src_reg; // RULE9
      end
    end
  end

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_isync_release;
    (state_reg == ST_ISYNC) && !core_in.older_busy;
  endsequence
  sequence s_flush_pulse;
    core_out.fetch_flush ##1 (!core_out.fetch_flush && state_reg == ST_IDLE);
  endsequence
  sequence s_sync_enter;
    exec && op == OP_SYNC;
  endsequence

  AST_MCRXR_COPY: assert property (exec && op == OP_MCRXR |=> // RULE1
    ((cond_reg & $past(crf_wide)) == ({PCO_CR_FIELDS{$past(fxe_top)}} & $past(crf_wide)))
    && ((cond_reg & ~$past(crf_wide)) == ($past(cond_reg) & ~$past(crf_wide))))
    else $error("exception bits not moved into condition field");
  AST_MCRXR_CLEAR: assert property (exec && op == OP_MCRXR |=> // RULE2
    fxe_reg[PCO_FXE_HI:PCO_FXE_LO] == '0 &&
    fxe_reg[PCO_FXE_LO-1:0] == $past(fxe_reg[PCO_FXE_LO-1:0]))
    else $error("exception bits not cleared after move");
  AST_MFCR: assert property (exec && op == OP_MFCR |=> dst_reg == $past(cond_reg)) // RULE3
    else $error("condition read result wrong");
  AST_MTCRF_LOAD: assert property (exec && op == OP_MTCRF |=> // RULE4
    (cond_reg & $past(crm_wide)) == ($past(src_reg) & $past(crm_wide)))
    else $error("masked field not loaded");
  AST_MTCRF_KEEP: assert property (exec && op == OP_MTCRF |=> // RULE7
    (cond_reg & ~$past(crm_wide)) == ($past(cond_reg) & ~$past(crm_wide)))
    else $error("unmasked field changed");
  AST_MFSPR: assert property (exec && op == OP_MFSPR && spr_hit |=> // RULE8
    dst_reg == $past(spr_file[spr_idx]))
    else $error("special read result wrong");
  AST_MTSPR: assert property (exec && op == OP_MTSPR && spr_hit |=> // RULE9
    spr_file[$past(spr_idx)] == $past(src_reg))
    else $error("special write not stored");
  AST_SYNC_WAIT: assert property ((state_reg == ST_SYNC) && // RULE19
    (core_in.older_busy || core_in.mem_busy) |=> state_reg == ST_SYNC && core_out.mem_hold)
    else $error("full barrier left with work outstanding");
  AST_SYNC_PATH: assert property (s_sync_enter |=> // RULE20
    core_out.mem_hold && core_out.issue_stall && !core_out.fetch_flush)
    else $error("ordering barrier not handled as full barrier");
  AST_ISYNC_WAIT: assert property ((state_reg == ST_ISYNC) && core_in.older_busy |=> // RULE13
    state_reg == ST_ISYNC && !core_out.fetch_flush)
    else $error("instruction barrier completed early");
  AST_ISYNC_FLUSH: assert property (s_isync_release |=> s_flush_pulse) // RULE15
    else $error("prefetch discard pulse missing");
  AST_ISYNC_NO_HOLD: assert property ((state_reg == ST_ISYNC) |-> !core_out.mem_hold) // RULE16
    else $error("instruction barrier held memory");
  AST_STALL_BUS: assert property (busy && dp_valid_reg && dp_write_reg |-> // RULE18
    !ahb_rsp.hreadyout)
    else $error("younger instruction accepted while busy");

endmodule : pco_top

// ### sim/pco_core_model.sv
`timescale 1ns/1ps
module pco_core_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bench command: load busy spans
  input wire logic go,
  input wire logic [7:0] older_n,
  input wire logic [7:0] mem_n,
  // Toward the block
  output pco_pkg::pco_core_in_type core_in
);
  import pco_pkg::*;

  logic [7:0] older_reg;
  logic [7:0] mem_reg;

  // Memory may outlive the pipeline, so the two barrier kinds can be told apart
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      older_reg <= 8'h00;
      mem_reg <= 8'h00;
    end else if (go) begin
      older_reg <= older_n;
      mem_reg <= mem_n;
    end else begin
      if (older_reg != 8'h00) older_reg <= older_reg - 8'h01;
      if (mem_reg != 8'h00) mem_reg <= mem_reg - 8'h01;
    end
  end

  assign core_in = '{older_busy: (older_reg != 8'h00), mem_busy: (mem_reg != 8'h00)};
endmodule : pco_core_model

// ### sim/processor_control_ops_bench.sv
`timescale 1ns/1ps
module processor_control_ops_bench;
  import pco_pkg::*;

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic go = 1'b0;
  logic [7:0] older_n = 8'h00;
  logic [7:0] mem_n = 8'h00;
  pco_ahb_req_type ahb_req;
  pco_ahb_rsp_type ahb_rsp;
  pco_core_in_type core_in;
  pco_core_out_type core_out;
  int fails = 0;
  int checks_done = 0;
  logic mon = 1'b0;
  logic bar_full = 1'b0;
  logic prev_st = 1'b0;
  logic rel_mem;
  int hold_n;
  int flush_n;
  int bad;

  always #4 hclk = ~hclk;

  assign ahb_req = {hsel, haddr, htrans, hwrite, hsize, hwdata, ahb_rsp.hreadyout};

  pco_top uut (.hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
    .core_in(core_in), .core_out(core_out));
  pco_core_model far (.hclk(hclk), .hresetn(hresetn), .go(go), .older_n(older_n),
    .mem_n(mem_n), .core_in(core_in));

  // Barrier monitor
  always @(posedge hclk) begin
    if (mon) begin
      if (core_out.mem_hold === 1'b1) hold_n <= hold_n + 1;
      if (core_out.fetch_flush === 1'b1) flush_n <= flush_n + 1;
      if ((core_in.older_busy === 1'b1 || (bar_full && core_in.mem_busy === 1'b1))
          && core_out.issue_stall !== 1'b1) bad <= bad + 1;
      if (prev_st === 1'b1 && core_out.issue_stall === 1'b0) rel_mem <= core_in.mem_busy;
    end
    prev_st <= core_out.issue_stall;
  end

  task summarize;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One single AHB transfer; starts right after an edge
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    int n;
    n = 0;
    haddr <= {20'h0_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do begin @(posedge hclk); n++; end while (ahb_rsp.hreadyout !== 1'b1 && n < 300);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (ahb_rsp.hreadyout !== 1'b1 && n < 300);
    rd = ahb_rsp.hrdata;
    if (n >= 300) chk("bus wait", 32'h0000_0000, 32'h0000_0001);
  endtask : bus

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    chk(nm, x, exp);
  endtask : rd_chk

  function automatic logic [31:0] ins(input logic [5:0] p, input logic [9:0] x,
                                      input logic [14:0] m);
    return {p, m, x, 1'b0};
  endfunction : ins

  // Number sits with its halves exchanged in the word
  function automatic logic [14:0] special_purpose_reg(input logic [9:0] n);
    return {5'h00, n[4:0], n[9:5]};
  endfunction : special_purpose_reg

  task t_reset;
    logic [31:0] x;
    rd_chk("cond reset", PCO_OFS_COND, 32'h0000_0000);
    rd_chk("fxe reset", PCO_OFS_FXE, 32'h0000_0000);
    rd_chk("dst reset", PCO_OFS_DST, 32'h0000_0000);
    rd_chk("status reset", PCO_OFS_STATUS, 32'h0000_0000);
    wr(12'h100, 32'hFFFF_FFFF);
    rd_chk("unmapped", 12'h100, 32'h0000_0000);
    chk("hresp okay", {31'h0, ahb_rsp.hresp}, 32'h0000_0000);
    wr(PCO_OFS_DST, 32'h1234_5678);
    rd_chk("dst read only", PCO_OFS_DST, 32'h0000_0000);
    wr(PCO_OFS_INSTR, 32'hFFFF_FFFF);
    bus(1'b0, PCO_OFS_STATUS, 32'h0000_0000, x);
    chk("unknown op", {31'h0, x[PCO_ST_BAD_OP]}, 32'h0000_0001);
  endtask : t_reset

  task t_mcrxr;
    logic [31:0] c;
    logic [31:0] e;
    int f;
    c = 32'h1234_5678;
    wr(PCO_OFS_COND, c);
    for (int i = 0; i < 3; i++) begin
      f = (i == 0) ? 0 : (i == 1) ? 5 : 7;
      e = 32'hB5A5_A5A5 ^ (32'(i) << 28);
      wr(PCO_OFS_FXE, e);
      wr(PCO_OFS_INSTR, ins(PCO_PRIM_X, PCO_XO_MCRXR, {3'(f), 12'h000}));
      c = (c & ~(32'h0000_000F << (28 - 4 * f))) | (32'(e[31:28]) << (28 - 4 * f));
      rd_chk("exc to cond", PCO_OFS_COND, c);
      rd_chk("exc cleared", PCO_OFS_FXE, e & 32'h0FFF_FFFF);
    end
  endtask : t_mcrxr

  task t_mfcr;
    wr(PCO_OFS_COND, 32'hC0DE_5A17);
    wr(PCO_OFS_INSTR, ins(PCO_PRIM_X, PCO_XO_MFCR, 15'h0000));
    rd_chk("cond read", PCO_OFS_DST, 32'hC0DE_5A17);
  endtask : t_mfcr

  task t_mtcrf;
    logic [7:0] masks [5];
    logic [31:0] e;
    masks = '{8'h64, 8'h80, 8'h01, 8'h00, 8'hFF};
    wr(PCO_OFS_SRC, 32'hABCD_EF98);
    foreach (masks[k]) begin
      wr(PCO_OFS_COND, 32'h1111_1111);
      wr(PCO_OFS_INSTR, ins(PCO_PRIM_X, PCO_XO_MTCRF, {6'h00, masks[k], 1'b0}));
      e = 32'h1111_1111;
      for (int j = 0; j < 8; j++) begin
        if (masks[k][7 - j]) e[31 - 4 * j -: 4] = 4'hA ^ 4'hA ^ 32'hABCD_EF98 >> (28 - 4 * j);
      end
      rd_chk("masked cond write", PCO_OFS_COND, e);
    end
  endtask : t_mtcrf

  task t_spr;
    logic [31:0] x;
    wr(PCO_OFS_SRC, 32'h5EED_0001);
    wr(PCO_OFS_INSTR, ins(PCO_PRIM_X, PCO_XO_MTSPR, special_purpose_reg(10'h001)));
    wr(PCO_OFS_SRC, 32'h5EED_0009);
    wr(PCO_OFS_INSTR, ins(PCO_PRIM_X, PCO_XO_MTSPR, special_purpose_reg(10'h009)));
    wr(PCO_OFS_SRC, 32'hFFFF_FFFF);
    wr(PCO_OFS_INSTR, ins(PCO_PRIM_X, PCO_XO_MTSPR, special_purpose_reg(10'h020)));
    wr(PCO_OFS_INSTR, ins(PCO_PRIM_X, PCO_XO_MFSPR, special_purpose_reg(10'h020)));
    rd_chk("spr out of range", PCO_OFS_DST, 32'h0000_0000);
    bus(1'b0, PCO_OFS_STATUS, 32'h0000_0000, x);
    chk("spr miss", {31'h0, x[PCO_ST_SPR_MISS]}, 32'h0000_0001);
    wr(PCO_OFS_INSTR, ins(PCO_PRIM_X, PCO_XO_MFSPR, special_purpose_reg(10'h001)));
    rd_chk("spr 1", PCO_OFS_DST, 32'h5EED_0001);
    wr(PCO_OFS_INSTR, ins(PCO_PRIM_X, PCO_XO_MFSPR, special_purpose_reg(10'h009)));
    rd_chk("spr 9", PCO_OFS_DST, 32'h5EED_0009);
  endtask : t_spr

  task t_bar(input logic [5:0] p, input logic [9:0] xo, input logic full);
    logic [31:0] x;
    int n;
    older_n <= full ? 8'h06 : 8'h0A;
    mem_n <= full ? 8'h10 : 8'h18;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    hold_n = 0;
    flush_n = 0;
    bad = 0;
    rel_mem = 1'bx;
    bar_full = full;
    wr(PCO_OFS_INSTR, ins(p, xo, 15'h0000));
    bus(1'b0, PCO_OFS_STATUS, 32'h0000_0000, x);
    chk("busy", {31'h0, x[PCO_ST_BUSY]}, 32'h0000_0001);
    chk("wait kind", {30'h0, x[PCO_ST_ISYNC], x[PCO_ST_SYNC]}, full ? 32'h1 : 32'h2);
    mon <= 1'b1;
    wr(PCO_OFS_COND, 32'h0BAD_F00D);
    mon <= 1'b0;
    rd_chk("write after barrier", PCO_OFS_COND, 32'h0BAD_F00D);
    chk("flush pulses", 32'(flush_n), full ? 32'h0 : 32'h1);
    chk("mem hold seen", 32'(hold_n > 0), 32'(full));
    chk("mem busy at release", {31'h0, rel_mem}, 32'(!full));
    chk("stall gaps", 32'(bad), 32'h0);
    n = 0;
    while (core_in.mem_busy !== 1'b0 && n < 100) begin @(posedge hclk); n++; end
  endtask : t_bar

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_mcrxr;
    t_mfcr;
    t_mtcrf;
    t_spr;
    t_bar(PCO_PRIM_X, PCO_XO_SYNC, 1'b1);
    t_bar(PCO_PRIM_X, PCO_XO_EIEIO, 1'b1);
    t_bar(PCO_PRIM_XL, PCO_XO_ISYNC, 1'b0);
    summarize;
  end

  // Whole run is well under a few thousand cycles
  initial begin
    #(8 * 20000);
    fails++;
    $display("wrong value watchdog expected finish seen hang");
    summarize;
  end
endmodule : processor_control_ops_bench
